//--- hw/iic_irq_ctrl.sv
// interrupt-clear registers, enable and abort control of the serial bus
//
// Contract
// RULE1: activity clear read works only when inactive
// RULE2: activity flag self-clears when disabled and idle
// RULE3: activity clear read returns activity flag
// RULE4: stop clear read clears stop flag
// RULE5: start clear read clears start flag
// RULE6: broadcast clear read clears broadcast flag
// RULE7: writing abort bit requests master abort
// RULE8: abort write ignored unless already enabled
// RULE9: abort bit sticks, reads one meanwhile
// RULE10: abort finishes transfer, stops, flushes, interrupts
// RULE11: abort bit self-clears when abort done
// RULE12: disabled holds both fifos flushed
// RULE13: masked status holds after disable until idle
// RULE14: disable while sending: finish, stop, discard
// RULE15: disable while receiving: stop, nack byte
// RULE16: enable change acts two clocks after write
// RULE17: busy flags define controller activity
// RULE18: clear registers touch one flag, read-only
`timescale 1ns/1ps
module iic_irq_ctrl
    import iic_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // serial bus pins, sampled only
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    // controller core, same clock
    input  wire logic        master_busy_flag,
    input  wire logic        slave_busy_flag,
    input  wire logic        broadcast_call_irq,
    // controls toward the core
    output logic             ctrl_enabled,
    output logic             abort_request,
    output logic             stop_request,
    output logic             tx_fifo_flush,
    output logic             rx_fifo_flush,
    output logic             finish_then_stop,
    output logic             rx_nack_stop,
    output logic [iic_pkg::IRQ_W-1:0] masked_irq_status,
    output logic             irq
);
    import iic_pkg::*;

    // ---------------- apb decode ----------------
    logic                 pready_q;
    logic                 pslverr_q;
    logic [31:0]          prdata_q;
    wire                  setup_w;
    wire                  done_w;
    wire                  wr_w;
    wire                  rd_w;
    wire                  hit_mask;
    wire                  hit_status;
    wire                  hit_act;
    wire                  hit_stop;
    wire                  hit_start;
    wire                  hit_bcast;
    wire                  hit_enable;
    wire                  hit_any;

    // zero wait state: pready rises in the first access cycle
    assign setup_w    = psel & ~penable;
    assign done_w     = psel & penable & pready_q;
    assign wr_w       = done_w & pwrite;
    assign rd_w       = done_w & ~pwrite;
    assign hit_mask   = (paddr == ADDR_IRQ_MASK);
    assign hit_status = (paddr == ADDR_IRQ_STATUS);
    assign hit_act    = (paddr == ADDR_ACT_CLR);
    assign hit_stop   = (paddr == ADDR_STOP_CLR);
    assign hit_start  = (paddr == ADDR_START_CLR);
    assign hit_bcast  = (paddr == ADDR_BCAST_CLR);
    assign hit_enable = (paddr == ADDR_ENABLE);
    assign hit_any    = hit_mask | hit_status | hit_act | hit_stop
                      | hit_start | hit_bcast | hit_enable;

    // ---------------- pin monitor ----------------
    logic                 scl_s;
    logic                 sda_s;
    logic                 sda_prev_q;
    logic                 bus_busy_q;
    wire                  start_seen_irq_w;
    wire                  stop_seen_irq_w;

    iic_sync2 #(
        .RESET_VAL (PIN_IDLE)
    ) u_sync_scl (
        .clk      (clk),
        .resetn   (resetn),
        .async_in (scl_in),
        .sync_out (scl_s)
    );

    iic_sync2 #(
        .RESET_VAL (PIN_IDLE)
    ) u_sync_sda (
        .clk      (clk),
        .resetn   (resetn),
        .async_in (sda_in),
        .sync_out (sda_s)
    );

    // data edge while the bus clock is high marks start or stop
    assign start_seen_irq_w = scl_s & sda_prev_q & ~sda_s;
    assign stop_seen_irq_w  = scl_s & ~sda_prev_q & sda_s;

    // bus stays busy from a start until the matching stop
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sda_prev_q <= PIN_IDLE;
            bus_busy_q <= 1'b0;
        end else begin
            sda_prev_q <= sda_s;
            bus_busy_q <= start_seen_irq_w | (bus_busy_q & ~stop_seen_irq_w);
        end
    end

    // ---------------- enable and abort ----------------
    logic                 enable_q;
    logic                 abort_q;
    logic                 abort_seen_q;
    logic [ENABLE_LATENCY-1:0] en_pipe_q;
    wire                  en_eff_w;
    wire                  en_next_w;
    wire                  active_w;
    wire                  en_wr_w;
    wire                  abort_set_w;
    wire                  abort_done_w;
    wire                  enable_d;
    wire                  abort_d;

    // state machines or the bus itself keep the controller active
    assign active_w  = master_busy_flag | slave_busy_flag
                     | bus_busy_q;                          // [RULE17]
    assign en_eff_w  = en_pipe_q[ENABLE_LATENCY-1];
    assign en_next_w = en_pipe_q[ENABLE_LATENCY-2];
    assign en_wr_w   = wr_w & hit_enable;
    // abort accepted only if enable was set before this write
    assign abort_set_w  = en_wr_w & pwdata[EN_ABORT_BIT]
                        & enable_q;                         // [RULE7] [RULE8]
    // done once the master machine is back at idle after the abort
    assign abort_done_w = abort_q & abort_seen_q
                        & ~master_busy_flag;                // [RULE10]
    assign enable_d = en_wr_w ? pwdata[EN_CTRL_BIT] : enable_q;
    // a zero write cannot clear abort; only completion does
    assign abort_d  = abort_set_w
                    | (abort_q & ~abort_done_w);            // [RULE9] [RULE11]

    always_ff @(posedge clk) begin
        if (!resetn) begin
            enable_q     <= ENABLE_RESET[EN_CTRL_BIT];
            abort_q      <= ENABLE_RESET[EN_ABORT_BIT];
            abort_seen_q <= 1'b0;
        end else begin
            enable_q     <= enable_d;
            abort_q      <= abort_d;
            abort_seen_q <= abort_q & ~abort_done_w;
        end
    end

    // enable reaches the core through a fixed two-stage delay
    always_ff @(posedge clk) begin
        if (!resetn) begin
            en_pipe_q <= '0;
        end else begin
            en_pipe_q <= {en_pipe_q[ENABLE_LATENCY-2:0],
                          enable_q};                        // [RULE16]
        end
    end

    // ---------------- sticky interrupt flags ----------------
    logic [NUM_FLAGS-1:0] flg_set;
    logic [NUM_FLAGS-1:0] flg_clr;
    logic [NUM_FLAGS-1:0] flg_q;
    logic [IRQ_W-1:0]     raw_w;
    logic [IRQ_W-1:0]     mask_q;
    logic [IRQ_W-1:0]     w1c_w;
    wire                  status_wr_w;
    wire                  auto_act_clr_w;

    assign status_wr_w = wr_w & hit_status;
    assign w1c_w       = status_wr_w ? pwdata[IRQ_W-1:0] : '0;
    // disabled and quiet: hardware drops activity on its own
    assign auto_act_clr_w = ~en_eff_w & ~active_w;          // [RULE2]

    // each clear register reaches its own flag only
    assign flg_set[FLG_ACT]    = active_w;
    assign flg_clr[FLG_ACT]    = (rd_w & hit_act) | auto_act_clr_w
                               | w1c_w[RAW_ACT_BIT];        // [RULE1] [RULE18]
    assign flg_set[FLG_STOP]   = stop_seen_irq_w;
    assign flg_clr[FLG_STOP]   = (rd_w & hit_stop)
                               | w1c_w[RAW_STOP_BIT];       // [RULE4]
    assign flg_set[FLG_START]  = start_seen_irq_w;
    assign flg_clr[FLG_START]  = (rd_w & hit_start)
                               | w1c_w[RAW_START_BIT];      // [RULE5]
    assign flg_set[FLG_BCAST]  = broadcast_call_irq;
    assign flg_clr[FLG_BCAST]  = (rd_w & hit_bcast)
                               | w1c_w[RAW_BCAST_BIT];      // [RULE6]
    assign flg_set[FLG_TXABRT] = abort_done_w;              // [RULE10]
    assign flg_clr[FLG_TXABRT] = w1c_w[RAW_TXABRT_BIT];

    // set wins inside each flag, so activity cannot clear while busy
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
            iic_sticky u_flag (
                .clk    (clk),
                .resetn (resetn),
                .set    (flg_set[gi]),
                .clr    (flg_clr[gi]),
                .flag_q (flg_q[gi])
            );
        end
    endgenerate

    // raw status layout, unimplemented bits read zero
    always_comb begin
        raw_w                 = '0;
        raw_w[RAW_ACT_BIT]    = flg_q[FLG_ACT];
        raw_w[RAW_STOP_BIT]   = flg_q[FLG_STOP];
        raw_w[RAW_START_BIT]  = flg_q[FLG_START];
        raw_w[RAW_BCAST_BIT]  = flg_q[FLG_BCAST];
        raw_w[RAW_TXABRT_BIT] = flg_q[FLG_TXABRT];
    end

    // mask register, same layout as raw status
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mask_q <= MASK_RESET;
        end else if (wr_w & hit_mask) begin
            mask_q <= pwdata[IRQ_W-1:0];
        end
    end

    // ---------------- read data ----------------
    logic [31:0]          rd_data_w;
    logic [REG_W-1:0]     enable_rd_w;
    logic [REG_W-1:0]     act_rd_w;
    logic [REG_W-1:0]     stop_rd_w;
    logic [REG_W-1:0]     start_rd_w;
    logic [REG_W-1:0]     bcast_rd_w;

    // clear registers show the flag in bit 0, reserved bits zero
    always_comb begin
        enable_rd_w               = '0;
        enable_rd_w[EN_CTRL_BIT]  = enable_q;
        enable_rd_w[EN_ABORT_BIT] = abort_q;                // [RULE9]
        act_rd_w                  = '0;
        act_rd_w[CLR_VALUE_BIT]   = flg_q[FLG_ACT];         // [RULE3]
        stop_rd_w                 = '0;
        stop_rd_w[CLR_VALUE_BIT]  = flg_q[FLG_STOP];
        start_rd_w                = '0;
        start_rd_w[CLR_VALUE_BIT] = flg_q[FLG_START];
        bcast_rd_w                = '0;
        bcast_rd_w[CLR_VALUE_BIT] = flg_q[FLG_BCAST];       // [RULE18]
    end

    assign rd_data_w =
        hit_enable ? {16'h0000, enable_rd_w} :
        hit_act    ? {16'h0000, act_rd_w}    :
        hit_stop   ? {16'h0000, stop_rd_w}   :
        hit_start  ? {16'h0000, start_rd_w}  :
        hit_bcast  ? {16'h0000, bcast_rd_w}  :
        hit_mask   ? {20'h00000, mask_q}     :
        hit_status ? {20'h00000, raw_w}      :
                     32'h0000_0000;

    // answer is fixed in setup; unmapped addresses get an error
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup_w;
            pslverr_q <= setup_w & ~hit_any;
            prdata_q  <= (setup_w & ~pwrite) ? rd_data_w : 32'h0000_0000;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ---------------- core controls ----------------
    logic                 ctrl_enabled_q;
    logic                 abort_request_q;
    logic                 stop_request_q;
    logic                 tx_flush_q;
    logic                 rx_flush_q;
    logic                 finish_stop_q;
    logic                 rx_nack_q;
    logic [IRQ_W-1:0]     masked_q;
    logic                 irq_q;
    wire  [IRQ_W-1:0]     masked_d;
    wire                  hold_status_w;

    // after disable the masked bits stay until the core is idle
    assign hold_status_w = en_eff_w | active_w;             // [RULE13]
    assign masked_d = (raw_w & mask_q) & {IRQ_W{hold_status_w}};

    // controls use the pipe stage one ahead so they line up with enable
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_enabled_q  <= 1'b0;
            abort_request_q <= 1'b0;
            stop_request_q  <= 1'b0;
            tx_flush_q      <= 1'b1;
            rx_flush_q      <= 1'b1;
            finish_stop_q   <= 1'b0;
            rx_nack_q       <= 1'b0;
            masked_q        <= '0;
            irq_q           <= 1'b0;
        end else begin
            ctrl_enabled_q  <= en_next_w;                   // [RULE16]
            abort_request_q <= abort_q;                     // [RULE7]
            stop_request_q  <= abort_q & master_busy_flag;  // [RULE10]
            // flush held while disabled; transmit flush also pulsed when an abort ends
            tx_flush_q      <= ~en_next_w | abort_done_w;   // [RULE12] [RULE14]
            rx_flush_q      <= ~en_next_w;                  // [RULE12]
            finish_stop_q   <= ~en_next_w & master_busy_flag; // [RULE14]
            rx_nack_q       <= ~en_next_w & slave_busy_flag;  // [RULE15]
            masked_q        <= masked_d;
            irq_q           <= |masked_d;
        end
    end

    assign ctrl_enabled      = ctrl_enabled_q;
    assign abort_request     = abort_request_q;
    assign stop_request      = stop_request_q;
    assign tx_fifo_flush     = tx_flush_q;
    assign rx_fifo_flush     = rx_flush_q;
    assign finish_then_stop  = finish_stop_q;
    assign rx_nack_stop      = rx_nack_q;
    assign masked_irq_status = masked_q;
    assign irq               = irq_q;
endmodule // iic_irq_ctrl

//--- hw/iic_pkg.sv
// constants and register map of the serial bus interrupt-clear slice
package iic_pkg;
    // register byte addresses
    localparam logic [31:0] ADDR_IRQ_MASK     = 32'h5000_1330;
    localparam logic [31:0] ADDR_IRQ_STATUS   = 32'h5000_1334;
    localparam logic [31:0] ADDR_ACT_CLR      = 32'h5000_135c;
    localparam logic [31:0] ADDR_STOP_CLR     = 32'h5000_1360;
    localparam logic [31:0] ADDR_START_CLR    = 32'h5000_1364;
    localparam logic [31:0] ADDR_BCAST_CLR    = 32'h5000_1368;
    localparam logic [31:0] ADDR_ENABLE       = 32'h5000_136c;

    // widths
    localparam int          REG_W             = 16;
    localparam int          IRQ_W             = 12;
    localparam int          NUM_FLAGS         = 5;

    // raw interrupt status bit positions
    localparam int          RAW_TXABRT_BIT    = 6;
    localparam int          RAW_ACT_BIT       = 8;
    localparam int          RAW_STOP_BIT      = 9;
    localparam int          RAW_START_BIT     = 10;
    localparam int          RAW_BCAST_BIT     = 11;

    // flag index of each sticky flag instance
    localparam int          FLG_ACT           = 0;
    localparam int          FLG_STOP          = 1;
    localparam int          FLG_START         = 2;
    localparam int          FLG_BCAST         = 3;
    localparam int          FLG_TXABRT        = 4;

    // enable and clear register fields
    localparam int          EN_CTRL_BIT       = 0;
    localparam int          EN_ABORT_BIT      = 1;
    localparam int          CLR_VALUE_BIT     = 0;

    // reset values
    localparam logic [REG_W-1:0] ENABLE_RESET = 16'h0000;
    localparam logic [IRQ_W-1:0] MASK_RESET   = 12'h000;
    localparam logic             PIN_IDLE     = 1'b1;

    // enable and disable take effect this many core clocks after the write
    localparam int          ENABLE_LATENCY    = 2;
endpackage : iic_pkg

//--- hw/iic_sticky.sv
// sticky interrupt flag, a set in the clear cycle wins
`timescale 1ns/1ps
module iic_sticky (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic set,
    input  wire logic clr,
    output logic      flag_q
);
    logic flag_d;

    // set beats clear so an event in the clearing cycle is kept
    assign flag_d = set | (flag_q & ~clr);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule // iic_sticky

//--- hw/iic_sync2.sv
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module iic_sync2 #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;

    // first stage is read only by the second stage
    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_q   <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // iic_sync2

//--- sim/iic_bus_dev.sv
// far-side bus device: start, byte and stop on the two pins
`timescale 1ns/1ps
module iic_bus_dev #(
    parameter int HALF = 100
) (
    output logic scl,
    output logic sda
);
    // pull-ups keep both lines high, the clock stands still between frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // data moves only while the clock is low, except for start and stop; each task first steps off
    // the core clock's rising edge so no pin change races the sampler
    task automatic start_cond;
        #(HALF/8);
        sda = 1'b0;
        #HALF scl = 1'b0;
    endtask

    // last slot is the ack, released so the pull-up reads high
    task automatic send_byte(input logic [7:0] b);
        #(HALF/8);
        for (int i = 8; i >= 0; i--) begin
            #(HALF/2) sda = (i == 0) ? 1'b1 : b[i-1];
            #(HALF/2) scl = 1'b1;
            #HALF scl = 1'b0;
        end
    endtask

    task automatic stop_cond;
        #(HALF/8);
        #(HALF/2) sda = 1'b0;
        #(HALF/2) scl = 1'b1;
        #HALF sda = 1'b1;
    endtask
endmodule // iic_bus_dev

//--- sim/iic_irq_ctrl_chk.sv
// port checks for the interrupt-clear and enable slice
`timescale 1ns/1ps
module iic_irq_ctrl_chk
    import iic_pkg::*;
(
    input wire logic                      clk,
    input wire logic                      resetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [31:0]               paddr,
    input wire logic [31:0]               pwdata,
    input wire logic [31:0]               prdata,
    input wire logic                      pready,
    input wire logic                      master_busy_flag,
    input wire logic                      ctrl_enabled,
    input wire logic                      abort_request,
    input wire logic                      stop_request,
    input wire logic                      tx_fifo_flush,
    input wire logic                      rx_fifo_flush,
    input wire logic [iic_pkg::IRQ_W-1:0] masked_irq_status,
    input wire logic                      irq
);
    // completed transfer, enable write, clear-register read
    wire acc    = psel && penable && pready;
    wire wr_en  = acc && pwrite && (paddr == ADDR_ENABLE);
    wire rd_clr = acc && !pwrite && (paddr inside
        {ADDR_ACT_CLR, ADDR_STOP_CLR, ADDR_START_CLR, ADDR_BCAST_CLR});
    logic en_bit_q;

    // own copy of the enable bit, since ctrl_enabled lags it
    always_ff @(posedge clk) begin
        if (!resetn) en_bit_q <= 1'b0;
        else if (wr_en) en_bit_q <= pwdata[EN_CTRL_BIT];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_ready_once: assert property (
        (psel && !penable) |=> pready ##1 !pready)
        else $error("pready not a single access cycle");
    a_clr_upper: assert property (
        rd_clr |-> (prdata[31:1] == 31'h0))
        else $error("clear register upper bits not zero");
    a_enable_on: assert property (
        wr_en && pwdata[0] |-> ##2 $stable(ctrl_enabled) ##1 ctrl_enabled)
        else $error("enable latency wrong");
    a_enable_off: assert property (
        wr_en && !pwdata[0] |-> ##2 $stable(ctrl_enabled) ##1 !ctrl_enabled)
        else $error("disable latency wrong");
    a_rx_flush: assert property (
        rx_fifo_flush == !ctrl_enabled)
        else $error("receive flush not tied to disable");
    a_abort_skip: assert property (
        wr_en && pwdata[1] && !en_bit_q && !abort_request
        |-> ##2 !abort_request)
        else $error("abort taken while disabled");
    a_abort_take: assert property (
        wr_en && pwdata[1] && en_bit_q && master_busy_flag
        |-> ##2 abort_request)
        else $error("abort request not raised");
    a_abort_hold: assert property (
        abort_request && master_busy_flag && $past(master_busy_flag)
        |=> abort_request)
        else $error("abort dropped while master busy");
    a_stop_tie: assert property (
        stop_request == (abort_request && $past(master_busy_flag)))
        else $error("stop request mismatch");
    a_flush_end: assert property (
        $fell(abort_request) && ctrl_enabled
        |-> $past(tx_fifo_flush) || $past(tx_fifo_flush, 2))
        else $error("no transmit flush at abort end");
    a_irq_level: assert property (
        irq == (|masked_irq_status))
        else $error("irq differs from masked status");
endmodule // iic_irq_ctrl_chk

bind iic_irq_ctrl iic_irq_ctrl_chk iic_irq_ctrl_chk_i (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .master_busy_flag(master_busy_flag),
    .ctrl_enabled(ctrl_enabled), .abort_request(abort_request),
    .stop_request(stop_request), .tx_fifo_flush(tx_fifo_flush),
    .rx_fifo_flush(rx_fifo_flush), .irq(irq),
    .masked_irq_status(masked_irq_status)
);

//--- sim/tb_iic_irq_ctrl.sv
// self-checking bench for the interrupt-clear and enable slice
`timescale 1ns/1ps
module tb_iic_irq_ctrl;
    import iic_pkg::*;
    logic             clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0]      paddr, pwdata, prdata, q;
    logic             scl, sda, err, irq, ctrl_enabled, abort_request;
    logic             master_busy_flag, slave_busy_flag, broadcast_call_irq;
    logic             stop_request, tx_fifo_flush, rx_fifo_flush;
    logic             finish_then_stop, rx_nack_stop;
    logic [IRQ_W-1:0] masked_irq_status;
    int               mismatches, n_checks, n_flush;

    // core clock, and a count of flush pulses seen while enabled
    always #12.5 clk = ~clk;
    always @(posedge clk)
        if (ctrl_enabled === 1'b1 && tx_fifo_flush === 1'b1) n_flush++;

    iic_bus_dev iic_bus_dev_i (.scl(scl), .sda(sda));
    iic_irq_ctrl iic_irq_ctrl_i (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda),
        .master_busy_flag(master_busy_flag),
        .slave_busy_flag(slave_busy_flag),
        .broadcast_call_irq(broadcast_call_irq),
        .ctrl_enabled(ctrl_enabled), .abort_request(abort_request),
        .stop_request(stop_request), .tx_fifo_flush(tx_fifo_flush),
        .rx_fifo_flush(rx_fifo_flush), .finish_then_stop(finish_then_stop),
        .rx_nack_stop(rx_nack_stop), .masked_irq_status(masked_irq_status),
        .irq(irq)
    );

    task automatic chk(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one transfer; the request stands until pready is sampled high,
    // and only the watchdog ends a wait that never sees it
    task automatic apb(input logic wr, input logic [31:0] a, d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        chk(pready, 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    task automatic wr(input logic [31:0] a, d);
        apb(1'b1, a, d);
    endtask

    // reset values, an unmapped read, then enable
    task automatic t_reset;
        rd(ADDR_ACT_CLR, 32'h0);
        rd(ADDR_ENABLE, 32'h0);
        chk(rx_fifo_flush & tx_fifo_flush, 1'b1);
        apb(1'b0, 32'h5000_13fc, 32'h0);
        chk(err, 1'b1);
        wr(ADDR_ENABLE, 32'h1);
        repeat (3) @(posedge clk);
        chk(ctrl_enabled, 1'b1);
        chk(rx_fifo_flush | tx_fifo_flush, 1'b0);
    endtask

    // start and stop from the far side; writes to clears do nothing
    task automatic t_start_stop;
        iic_bus_dev_i.start_cond();
        repeat (12) @(posedge clk);
        rd(ADDR_START_CLR, 32'h1);
        rd(ADDR_START_CLR, 32'h0);
        iic_bus_dev_i.send_byte(8'ha5);
        iic_bus_dev_i.stop_cond();
        repeat (12) @(posedge clk);
        wr(ADDR_STOP_CLR, 32'hffff);
        rd(ADDR_IRQ_STATUS, 32'h300);
        rd(ADDR_STOP_CLR, 32'h1);
        rd(ADDR_STOP_CLR, 32'h0);
    endtask

    // activity flag survives reads while busy
    task automatic t_activity;
        master_busy_flag <= 1'b1;
        repeat (2) @(posedge clk);
        rd(ADDR_ACT_CLR, 32'h1);
        rd(ADDR_ACT_CLR, 32'h1);
        master_busy_flag <= 1'b0;
        rd(ADDR_ACT_CLR, 32'h1);
        rd(ADDR_ACT_CLR, 32'h0);
    endtask

    // broadcast call through the mask to the interrupt line
    task automatic t_bcast;
        wr(ADDR_IRQ_MASK, 32'h800);
        broadcast_call_irq <= 1'b1;
        @(posedge clk);
        broadcast_call_irq <= 1'b0;
        repeat (3) @(posedge clk);
        chk(irq, 1'b1);
        rd(ADDR_BCAST_CLR, 32'h1);
        rd(ADDR_IRQ_STATUS, 32'h0);
        chk(irq, 1'b0);
    endtask

    // abort refused while disabled, sticky, then flush and flag
    task automatic t_abort;
        wr(ADDR_ENABLE, 32'h0);
        wr(ADDR_ENABLE, 32'h2);
        rd(ADDR_ENABLE, 32'h0);
        wr(ADDR_ENABLE, 32'h3);
        rd(ADDR_ENABLE, 32'h1);
        master_busy_flag <= 1'b1;
        n_flush = 0;
        wr(ADDR_ENABLE, 32'h3);
        rd(ADDR_ENABLE, 32'h3);
        chk(stop_request, 1'b1);
        wr(ADDR_ENABLE, 32'h1);
        rd(ADDR_ENABLE, 32'h3);
        master_busy_flag <= 1'b0;
        repeat (4) @(posedge clk);
        rd(ADDR_ENABLE, 32'h1);
        chk(n_flush, 32'h1);
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
        chk(q & 32'h40, 32'h40);
        wr(ADDR_IRQ_STATUS, 32'h40);
    endtask

    // disable while busy: masked status held until idle
    task automatic t_disable;
        wr(ADDR_IRQ_MASK, 32'h100);
        master_busy_flag <= 1'b1;
        slave_busy_flag <= 1'b1;
        wr(ADDR_ENABLE, 32'h0);
        repeat (4) @(posedge clk);
        chk(finish_then_stop, 1'b1);
        chk(rx_nack_stop, 1'b1);
        chk(masked_irq_status[RAW_ACT_BIT], 1'b1);
        rd(ADDR_ACT_CLR, 32'h1);
        master_busy_flag <= 1'b0;
        slave_busy_flag <= 1'b0;
        repeat (4) @(posedge clk);
        chk(irq, 1'b0);
        rd(ADDR_IRQ_STATUS, 32'h0);
    endtask

    task automatic conclude;
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // main sequence
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {master_busy_flag, slave_busy_flag, broadcast_call_irq} = '0;
        mismatches = 0;
        n_checks = 0;
        n_flush = 0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_start_stop();
        t_activity();
        t_bcast();
        t_abort();
        t_disable();
        conclude();
    end

    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #200_000;
        mismatches++;
        $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        conclude();
    end
endmodule // tb_iic_irq_ctrl
